//--- core/pfc_pkg.sv
`default_nettype none
package pfc_pkg;
	// Position of the data-type code and value field in a write request
	localparam int unsigned FMT_BYTE = 10;
	localparam int unsigned VAL_BYTE = 12;
	localparam int unsigned FRAME_MAX = 16;
	localparam int unsigned VAL_MAX = 4;
	// Parameter number sits in bytes 6 and 7, high byte first
	localparam int unsigned PNU_HI_BYTE = 6;
	localparam int unsigned PNU_LO_BYTE = 7;
	// Data-type codes; all but C_NORM32 are accepted
	localparam logic [7:0] C_INT16 = 8'h03;
	localparam logic [7:0] C_UNS8 = 8'h05;
	localparam logic [7:0] C_UNS16 = 8'h06;
	localparam logic [7:0] C_UNS32 = 8'h07;
	localparam logic [7:0] C_OCTSTR = 8'h0A;
	localparam logic [7:0] C_TDIFF = 8'h0D;
	localparam logic [7:0] C_ZERO = 8'h40;
	localparam logic [7:0] C_BYTE = 8'h41;
	localparam logic [7:0] C_WORD = 8'h42;
	localparam logic [7:0] C_DWORD = 8'h43;
	localparam logic [7:0] C_ERROR = 8'h44;
	localparam logic [7:0] C_NORM16 = 8'h71;
	localparam logic [7:0] C_NORM32 = 8'h72;
	localparam logic [7:0] C_FLAGS16 = 8'h73;
	localparam logic [7:0] C_TCONST16 = 8'h76;
	localparam logic [7:0] C_TCONST32 = 8'h77;
	localparam logic [7:0] C_FINE_TC = 8'h78;
	// Parameter-channel error numbers
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_DATA_TYPE = 8'h05;
	// Normalized 16-bit: 4000 hex is one hundred percent
	localparam logic [15:0] NORM16_ONE = 16'h4000;
	localparam int unsigned NORM16_FRAC = 14;
	// Sampling-time parameter number; no logic uses it to scale time values
	localparam logic [15:0] PNU_SAMPLE_TIME = 16'h03C2;
	// Value-length class: one or more bytes allowed
	localparam logic [2:0] LEN_VAR = 3'h7;
	localparam logic [2:0] LEN_BAD = 3'h6;
	typedef enum logic [1:0] {PFC_IDLE, PFC_COLLECT, PFC_CHECK} pfc_state_e;
endpackage : pfc_pkg
`default_nettype wire

//--- core/pfc_value_buf.sv
`default_nettype none
// Small byte store that holds the value field of one request
module pfc_value_buf (
	input wire logic i_mclk,
	input wire logic i_wr,
	input wire logic [1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	output logic [31:0] o_word
);
	logic [7:0] mem [0:3];
	// Octet 1 lands in the top byte, matching the big-endian value order
	always_ff @(posedge i_mclk) begin
		if (i_wr) begin
			mem[i_waddr] <= i_wdata;
		end
		o_word <= {mem[0], mem[1], mem[2], mem[3]};
	end
endmodule // pfc_value_buf
`default_nettype wire

//--- core/pfc_format_checker.sv
// Summary of operation
// - Take format from byte 10, accept listed codes
// - Standard boolean, int8/32, float, string, dates rejected
// - Norm16 spans -200% to +200%, 4000h=100%
// - Norm32 code 72h is rejected
// - Normalized top bit is sign, then descending weights
// - Time-difference 0Dh taken as four bytes, not scaled
// - Time constants 76h two bytes, 77h four
// - Nibble, reciprocal, fixed-point, variable normalized rejected
// - Flag sequence: flag 15 top of octet one
`default_nettype none
module pfc_format_checker (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_frame_end,
	input wire logic [7:0] i_param_type,
	output logic o_done,
	output logic o_store,
	output logic o_error,
	output logic [7:0] o_error_num,
	output logic [7:0] o_format,
	output logic [31:0] o_value,
	output logic [2:0] o_value_len,
	output logic o_sign_flag,
	output logic [15:0] o_parameter_number
);
	pfc_pkg::pfc_state_e state;
	logic [4:0] idx;
	logic [7:0] fmt;
	logic [2:0] vcount;
	logic [15:0] parameter_number;
	logic [31:0] word;
	logic check_d;

	// Expected value length per code; LEN_BAD marks every code not accepted
	function automatic logic [2:0] fmt_len(input logic [7:0] c);
		case (c)
			pfc_pkg::C_INT16, pfc_pkg::C_UNS16, pfc_pkg::C_WORD, pfc_pkg::C_ERROR: fmt_len = 3'd2;
			pfc_pkg::C_NORM16, pfc_pkg::C_FLAGS16, pfc_pkg::C_FINE_TC: fmt_len = 3'd2;
			pfc_pkg::C_TCONST16: fmt_len = 3'd2;
			pfc_pkg::C_TCONST32: fmt_len = 3'd4;
			pfc_pkg::C_UNS8, pfc_pkg::C_BYTE: fmt_len = 3'd1;
			pfc_pkg::C_UNS32, pfc_pkg::C_TDIFF, pfc_pkg::C_DWORD: fmt_len = 3'd4;
			pfc_pkg::C_ZERO: fmt_len = 3'd0;
			pfc_pkg::C_OCTSTR: fmt_len = pfc_pkg::LEN_VAR;
			default: fmt_len = pfc_pkg::LEN_BAD;
		endcase
	endfunction

	wire in_hdr = (state == pfc_pkg::PFC_COLLECT) && i_byte_valid;
	wire is_fmt = in_hdr && (idx == 5'(pfc_pkg::FMT_BYTE));
	wire is_pnu_hi = in_hdr && (idx == 5'(pfc_pkg::PNU_HI_BYTE));
	wire is_pnu_lo = in_hdr && (idx == 5'(pfc_pkg::PNU_LO_BYTE));
	// Bytes beyond four value bytes are neither counted nor stored
	wire is_val = in_hdr && (idx >= 5'(pfc_pkg::VAL_BYTE)) && (vcount < 3'(pfc_pkg::VAL_MAX));
	wire [2:0] exp_len = fmt_len(fmt);
	wire len_ok = (exp_len == pfc_pkg::LEN_VAR) ? (vcount != 3'd0) : (exp_len == vcount);
	wire type_ok = (exp_len != pfc_pkg::LEN_BAD) && (fmt == i_param_type);
	wire accept = type_ok && len_ok;
	wire start = (state == pfc_pkg::PFC_IDLE) && i_byte_valid;
	// Right-justify the collected bytes so the last octet is bits 7:0 for any length
	wire [31:0] val_aligned = (vcount == 3'd1) ? {24'h000000, word[31:24]} :
		(vcount == 3'd2) ? {16'h0000, word[31:16]} :
		(vcount == 3'd3) ? {8'h00, word[31:8]} :
		(vcount == 3'd0) ? 32'h00000000 : word;
	wire sign_of = (fmt == pfc_pkg::C_NORM16) && val_aligned[15];

	pfc_value_buf u_buf (
		.i_mclk(i_mclk),
		.i_wr(is_val),
		.i_waddr(vcount[1:0]),
		.i_wdata(i_byte),
		.o_word(word)
	);

	// Frame walk: first byte starts, frame end triggers the check
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state <= pfc_pkg::PFC_IDLE;
			idx <= 5'd0;
		end else begin
			case (state)
				pfc_pkg::PFC_IDLE: begin
					if (start) begin
						state <= pfc_pkg::PFC_COLLECT;
						idx <= 5'd1;
					end
				end
				pfc_pkg::PFC_COLLECT: begin
					if (i_frame_end) begin
						state <= pfc_pkg::PFC_CHECK;
					end else if (i_byte_valid && idx < 5'(pfc_pkg::FRAME_MAX)) begin
						idx <= idx + 5'd1;
					end
				end
				pfc_pkg::PFC_CHECK: begin
					state <= pfc_pkg::PFC_IDLE;
					idx <= 5'd0;
				end
				default: state <= pfc_pkg::PFC_IDLE;
			endcase
		end
	end

	// Header capture; a single-byte frame ends in COLLECT with no format seen
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || start) begin
			fmt <= 8'h00;
			vcount <= 3'd0;
			parameter_number <= 16'h0000;
		end else begin
			if (is_fmt) fmt <= i_byte;
			if (is_pnu_hi) parameter_number[15:8] <= i_byte;
			if (is_pnu_lo) parameter_number[7:0] <= i_byte;
			if (is_val) vcount <= vcount + 3'd1;
		end
	end

	// Buffer read data is a cycle late, so results issue two cycles after CHECK
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			check_d <= 1'b0;
			o_done <= 1'b0;
			o_store <= 1'b0;
			o_error <= 1'b0;
			o_error_num <= pfc_pkg::ERR_NONE;
			o_format <= 8'h00;
			o_value <= 32'h00000000;
			o_value_len <= 3'd0;
			o_sign_flag <= 1'b0;
			o_parameter_number <= 16'h0000;
		end else begin
			check_d <= (state == pfc_pkg::PFC_CHECK);
			o_done <= check_d;
			o_store <= check_d && accept;
			o_error <= check_d && !accept;
			if (check_d) begin
				o_error_num <= accept ? pfc_pkg::ERR_NONE : pfc_pkg::ERR_DATA_TYPE;
				o_format <= fmt;
				o_value <= val_aligned;
				o_value_len <= vcount;
				o_sign_flag <= sign_of;
				o_parameter_number <= parameter_number;
			end
		end
	end

	property p_store_accept;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_store |-> $past(type_ok) && $past(len_ok);
	endproperty
	a_store_accept: assert property (p_store_accept) else $error("store without valid format");

	property p_reject_norm32;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && o_format == pfc_pkg::C_NORM32 |-> o_error && !o_store;
	endproperty
	a_reject_norm32: assert property (p_reject_norm32) else $error("norm32 accepted");

	property p_reject_std;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && (o_format == 8'h01 || o_format == 8'h02 || o_format == 8'h04 || o_format == 8'h08) |-> o_error;
	endproperty
	a_reject_std: assert property (p_reject_std) else $error("standard code accepted");

	property p_reject_prof;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && (o_format == 8'h74 || o_format == 8'h75 || o_format == 8'h79 || o_format == 8'h7A ||
			o_format == 8'h7C) |-> o_error;
	endproperty
	a_reject_prof: assert property (p_reject_prof) else $error("profile code accepted");

	// String and calendar codes would need more than four value bytes, so they stay refused
	property p_reject_std_more;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && (o_format == 8'h09 || o_format == 8'h0C || o_format == 8'h32 || o_format == 8'h34 ||
			o_format == 8'h35 || o_format == 8'h36) |-> o_error && !o_store;
	endproperty
	a_reject_std_more: assert property (p_reject_std_more) else $error("string or date code accepted");

	property p_flags_len;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_store && o_format == pfc_pkg::C_FLAGS16 |-> o_value_len == 3'd2 && o_value[31:16] == 16'h0000;
	endproperty
	a_flags_len: assert property (p_flags_len) else $error("flag sequence not two octets");

	property p_norm16_len;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_store && o_format == pfc_pkg::C_NORM16 |-> o_value_len == 3'd2 && o_value[31:16] == 16'h0000;
	endproperty
	a_norm16_len: assert property (p_norm16_len) else $error("normalized value not two octets");

	property p_tconst_len;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_store && o_format == pfc_pkg::C_TCONST32 |-> o_value_len == 3'd4;
	endproperty
	a_tconst_len: assert property (p_tconst_len) else $error("tconst32 length wrong");

	property p_tdiff_len;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_store && o_format == pfc_pkg::C_TDIFF |-> o_value_len == 3'd4;
	endproperty
	a_tdiff_len: assert property (p_tdiff_len) else $error("tdiff length wrong");

	property p_sign;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && o_format == pfc_pkg::C_NORM16 |-> o_sign_flag == o_value[15];
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag mismatch");

	// Only the normalized format carries a sign bit; other codes must not leak one
	property p_sign_other;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done && o_format != pfc_pkg::C_NORM16 |-> !o_sign_flag;
	endproperty
	a_sign_other: assert property (p_sign_other) else $error("sign flag on other format");

	property p_err_exclusive;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_done |-> (o_store ^ o_error) && (o_error == (o_error_num == pfc_pkg::ERR_DATA_TYPE));
	endproperty
	a_err_exclusive: assert property (p_err_exclusive) else $error("result flags inconsistent");

	property p_done_timing;
		@(posedge i_mclk) disable iff (i_sys_rst)
		state == pfc_pkg::PFC_CHECK |-> ##2 o_done;
	endproperty
	a_done_timing: assert property (p_done_timing) else $error("done not two cycles after check");

	c_store: cover property (@(posedge i_mclk) o_store && o_format == pfc_pkg::C_NORM16);
	c_error: cover property (@(posedge i_mclk) o_error);
	c_octstr: cover property (@(posedge i_mclk) o_store && o_format == pfc_pkg::C_OCTSTR);
	c_zero: cover property (@(posedge i_mclk) o_store && o_format == pfc_pkg::C_ZERO);
endmodule // pfc_format_checker
`default_nettype wire

//--- dv/pfc_master_model.sv
`default_nettype none
// Fieldbus master: sends one write request a byte a cycle
module pfc_master_model (
	input wire logic i_mclk,
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	output logic o_frame_end
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
		o_frame_end = 1'b0;
	end
	// Value field sized by n, not by the format; callers keep it at four bytes or fewer
	task automatic send(input logic [7:0] fmt, input int n, input logic [15:0] parameter_number, input logic [31:0] val);
		logic [7:0] b;
		for (int i = 0; i < 12 + n; i++) begin
			@(negedge i_mclk);
			case (i)
				0: b = 8'h01;
				1: b = 8'h02;
				3: b = 8'h01;
				4: b = 8'h10;
				6: b = parameter_number[15:8];
				7: b = parameter_number[7:0];
				10: b = fmt;
				11: b = 8'h01;
				default: b = (i >= 12) ? val[8*(n-1-(i-12)) +: 8] : 8'h00;
			endcase
			o_byte_valid = 1'b1;
			o_byte = b;
		end
		// Idle bus shows the inverse, so a stale byte cannot pass
		@(negedge i_mclk);
		o_byte_valid = 1'b0;
		o_byte = ~b;
		o_frame_end = 1'b1;
		@(negedge i_mclk);
		o_frame_end = 1'b0;
	endtask
endmodule // pfc_master_model
`default_nettype wire

//--- dv/pfc_format_checker_tb_top.sv
`default_nettype none
module pfc_format_checker_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0, i_sys_rst = 1'b1, bv, fe, o_done, o_store, o_error, o_sign_flag;
	logic [7:0] bt, ptype = 8'h00, o_error_num, o_format;
	logic [31:0] o_value;
	logic [2:0] o_value_len;
	logic [15:0] o_parameter_number, rnd = 16'h9795;
	int mismatches = 0, n_tests = 0;
	pfc_format_checker DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_byte_valid(bv), .i_byte(bt),
		.i_frame_end(fe), .i_param_type(ptype), .o_done(o_done), .o_store(o_store), .o_error(o_error),
		.o_error_num(o_error_num), .o_format(o_format), .o_value(o_value), .o_value_len(o_value_len),
		.o_sign_flag(o_sign_flag), .o_parameter_number(o_parameter_number));
	pfc_master_model m (.i_mclk(i_mclk), .o_byte_valid(bv), .o_byte(bt), .o_frame_end(fe));
	initial forever #20 i_mclk = ~i_mclk;
	task automatic summarize();
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Reference length per code; -1 marks a refused code, 0A needs one or more
	function automatic int exp_len(input logic [7:0] c);
		case (c)
			8'h03, 8'h06, 8'h42, 8'h44, 8'h71, 8'h73, 8'h76, 8'h78: return 2;
			8'h05, 8'h41, 8'h0A: return 1;
			8'h07, 8'h0D, 8'h43, 8'h77: return 4;
			8'h40: return 0;
			default: return -1;
		endcase
	endfunction
	// Galois shift register keeps the random values repeatable
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
	endfunction
	// One request, then the result compared with the reference
	task automatic run(input logic [7:0] fmt, input int n, input logic [7:0] t, input bit ok);
		logic [31:0] val;
		logic [31:0] exp_v;
		logic [7:0] q[$];
		int k;
		rnd = lfsr(rnd);
		val = {rnd, ~rnd};
		if (n < 4) val = val & ((32'h1 << (8 * n)) - 32'h1);
		// Reference model: value octets queued first to last, at most four kept
		for (k = n - 1; k >= 0; k--) begin
			if (q.size() < 4) q.push_back(val[8*k +: 8]);
		end
		exp_v = 32'h0;
		foreach (q[j]) exp_v = (exp_v << 8) | {24'h0, q[j]};
		// Target type changes on the falling edge, one cycle before the frame starts
		@(negedge i_mclk);
		ptype = t;
		m.send(fmt, n, rnd, val);
		for (k = 0; k < 10 && o_done !== 1'b1; k++) begin
			@(posedge i_mclk);
			#1;
		end
		if (o_done !== 1'b1) begin
			mismatches++;
			summarize();
		end else begin
			check({31'h0, o_store}, {31'h0, ok});
			check({31'h0, o_error}, {31'h0, !ok});
			check({24'h0, o_error_num}, ok ? 32'h0 : 32'h5);
			check({24'h0, o_format}, {24'h0, fmt});
			check(o_value, exp_v);
			check({29'h0, o_value_len}, n);
			check({16'h0, o_parameter_number}, {16'h0, rnd});
			check({31'h0, o_sign_flag}, {31'h0, fmt == 8'h71 && val[15]});
		end
	endtask
	initial begin
		int l;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		i_sys_rst = 1'b0;
		// Codes 00h to 7Fh with their own length; refused codes carry four bytes
		for (int c = 0; c < 128; c++) begin
			l = exp_len(c[7:0]);
			run(c[7:0], (l < 0) ? 4 : l, c[7:0], l >= 0);
		end
		// Mid-run reset must clear the held results of the last frame
		@(negedge i_mclk);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_mclk);
		check({24'h0, o_format}, 32'h0);
		check(o_value, 32'h0);
		check({16'h0, o_parameter_number}, 32'h0);
		check({24'h0, o_error_num}, 32'h0);
		check({29'h0, o_done, o_store, o_error}, 32'h0);
		check({31'h0, o_sign_flag}, 32'h0);
		i_sys_rst = 1'b0;
		run(8'hC7, 2, 8'hC7, 0);
		run(8'h72, 4, 8'h72, 0);
		run(8'h71, 2, 8'h70, 0);
		run(8'h07, 2, 8'h07, 0);
		run(8'h40, 1, 8'h40, 0);
		run(8'h0A, 3, 8'h0A, 1);
		for (int i = 0; i < 8; i++) run(8'h71, 2, 8'h71, 1);
		summarize();
	end
endmodule // pfc_format_checker_tb_top
`default_nettype wire
